// ### plfm_map.svh
// address, opcode and timing constants for the data move executor
// assumes it is included by bare name from the resolver and executor files
`ifndef PLFM_MAP_SVH
`define PLFM_MAP_SVH
`define PLFM_OP1_TOP      3'h2
`define PLFM_OP2_TOP      8'h01
`define PLFM_LOW_MAX      8'h1F
`define PLFM_ACC_ADDR     8'h0A
`define PLFM_IND0_ADDR    8'h00
`define PLFM_IND1_ADDR    8'h08
`define PLFM_PTR0_ADDR    8'h01
`define PLFM_PTR1_ADDR    8'h09
`define PLFM_ACC_RST      8'h00
`define PLFM_Q_LAST       2'h3
`endif

// ### plfm_pkg.sv
// shared types for the data move executor
// assumes the map header defines the address constants
package plfm_pkg;
    typedef logic [7:0]  plfm_byte_t;
    typedef logic [15:0] plfm_word_t;
    typedef enum logic [3:0] {
        PLFM_Q1 = 4'b0001,
        PLFM_Q2 = 4'b0010,
        PLFM_Q3 = 4'b0100,
        PLFM_Q4 = 4'b1000
    } plfm_phase_t;
endpackage

// ### plfm_addr_resolve.sv
// resolves an operand address through the indirect pointers
// assumes pointer values are held by the caller and stable during use
`timescale 1ns/100ps
`include "plfm_map.svh"
module plfm_addr_resolve
    import plfm_pkg::*;
(
    // raw operand and pointers
    input  wire plfm_pkg::plfm_byte_t rawAddr,
    input  wire plfm_pkg::plfm_byte_t ptr0,
    input  wire plfm_pkg::plfm_byte_t ptr1,
    // effective address
    output wire plfm_pkg::plfm_byte_t effAddr
);
    import plfm_pkg::*;
    // indirect registers stand for the byte their pointer names
    wire isInd0 = (rawAddr == `PLFM_IND0_ADDR);
    wire isInd1 = (rawAddr == `PLFM_IND1_ADDR);
    assign effAddr = isInd0 ? ptr0 : (isInd1 ? ptr1 : rawAddr);
endmodule

// ### plfm_exec.sv
// executes the low-region-to-data and accumulator-to-data moves
// assumes one data port with combinational read and a four-phase cycle
`timescale 1ns/100ps
`include "plfm_map.svh"
module plfm_exec
    import plfm_pkg::*;
(
    // clock and control
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  clkEn,
    // instruction from fetch, taken at the first phase
    input  wire plfm_pkg::plfm_word_t instrWord,
    input  wire                  instrValid,
    // indirect pointers held by the core
    input  wire plfm_pkg::plfm_byte_t ptr0,
    input  wire plfm_pkg::plfm_byte_t ptr1,
    // data memory port
    input  wire plfm_pkg::plfm_byte_t memRdData,
    output var   plfm_pkg::plfm_byte_t memAddr,
    output var   plfm_pkg::plfm_byte_t memWrData,
    output logic                 memWrEn,
    // accumulator and status
    output var   plfm_pkg::plfm_byte_t accValue,
    output logic                 zeroFlag,
    output logic                 busy
);
    import plfm_pkg::*;

    plfm_phase_t phase_r, phase_nxt;
    plfm_word_t  instr_r;
    logic        act_r;
    plfm_byte_t  data_r;
    plfm_byte_t  acc_r, acc_nxt;
    logic        zero_r;

    // opcode decode of the latched word
    function automatic logic [1:0] plfmDecode(input plfm_word_t w);
        plfmDecode = {w[15:8] == `PLFM_OP2_TOP, w[15:13] == `PLFM_OP1_TOP};
    endfunction

    wire [1:0] dec     = plfmDecode(instr_r);
    wire       isLow   = act_r & dec[0];
    wire       isAcc   = act_r & dec[1];
    wire plfm_byte_t srcRaw = {3'h0, instr_r[12:8]};
    wire plfm_byte_t dstRaw = instr_r[7:0];
    wire plfm_byte_t srcEff;
    wire plfm_byte_t dstEff;

    // both operands go through indirect resolution
    plfm_addr_resolve srcRes (
        .rawAddr (srcRaw),
        .ptr0    (ptr0),
        .ptr1    (ptr1),
        .effAddr (srcEff)
    );
    plfm_addr_resolve dstRes (
        .rawAddr (dstRaw),
        .ptr0    (ptr0),
        .ptr1    (ptr1),
        .effAddr (dstEff)
    );

    // the accumulator lives here, so its reads and writes bypass memory
    wire        srcIsAcc = (srcEff == `PLFM_ACC_ADDR);
    wire        dstIsAcc = (dstEff == `PLFM_ACC_ADDR);
    wire plfm_byte_t srcByte = srcIsAcc ? acc_r : memRdData;
    wire plfm_byte_t moveVal = isLow ? data_r : acc_r;
    wire        doWrite  = (phase_r == PLFM_Q4) & (isLow | isAcc);

    // phase sequencer
    always_comb begin
        unique case (phase_r)
            PLFM_Q1: phase_nxt = PLFM_Q2;
            PLFM_Q2: phase_nxt = PLFM_Q3;
            PLFM_Q3: phase_nxt = PLFM_Q4;
            PLFM_Q4: phase_nxt = PLFM_Q1;
            default: phase_nxt = PLFM_Q1;
        endcase
    end

    // a write aimed at the accumulator lands here, memory is left alone
    always_comb begin
        acc_nxt = acc_r;
        if (doWrite & dstIsAcc) begin
            acc_nxt = moveVal;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase_r <= PLFM_Q1;
        end else if (clkEn) begin
            phase_r <= phase_nxt;
        end
    end

    // instruction latch at decode phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            instr_r <= 16'h0000;
            act_r   <= 1'b0;
        end else if (clkEn && phase_r == PLFM_Q1) begin
            instr_r <= instrWord;
            act_r   <= instrValid;
        end
    end

    // source read while the port shows the source, i.e. through the third phase
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            data_r <= 8'h00;
        end else if (clkEn && phase_r == PLFM_Q3 && isLow) begin
            data_r <= srcByte;
        end
    end

    // accumulator and zero flag; only the low-region move touches zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_r  <= `PLFM_ACC_RST;
            zero_r <= 1'b0;
        end else if (clkEn) begin
            acc_r <= acc_nxt;
            if (phase_r == PLFM_Q4 && isLow) begin
                zero_r <= (data_r == 8'h00);
            end
        end
    end

    // memory port registered so outputs come from flops; the source address
    // waits one phase so it is built from the freshly latched word
    wire plfm_byte_t addrNxt = (phase_nxt == PLFM_Q3) ? srcEff : dstEff;
    wire        wrNxt   = (phase_nxt == PLFM_Q4) & (isLow | isAcc)
                          & ~dstIsAcc;
    wire plfm_byte_t wdNxt = (phase_nxt == PLFM_Q4 && isLow) ? srcByte : acc_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            memAddr   <= 8'h00;
            memWrData <= 8'h00;
            memWrEn   <= 1'b0;
            accValue  <= `PLFM_ACC_RST;
            zeroFlag  <= 1'b0;
            busy      <= 1'b0;
        end else if (clkEn) begin
            memAddr   <= addrNxt;
            memWrData <= wdNxt;
            memWrEn   <= wrNxt;
            accValue  <= acc_nxt;
            zeroFlag  <= zero_r;
            busy      <= isLow | isAcc;
        end
    end
endmodule

// ### plfm_data_mem.sv
// data memory model facing the move executor
// assumes combinational read and a write at the clock edge
`timescale 1ns/100ps
module plfm_data_mem
    import plfm_pkg::*;
(
    // memory port
    input  wire                  clk,
    input  wire plfm_pkg::plfm_byte_t addr,
    input  wire plfm_pkg::plfm_byte_t wrData,
    input  wire                  wrEn,
    output wire plfm_pkg::plfm_byte_t rdData
);
    plfm_byte_t mem [256];
    // distinct bytes, the only zero sits at 07h
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h07;
    assign rdData = mem[addr];
    // write lands on the edge closing the write phase
    always @(posedge clk) if (wrEn) mem[addr] <= wrData;
endmodule

// ### plfm_exec_assertions.sv
// timing checks on the move executor ports
// assumes one clock domain and an active low reset
`timescale 1ns/100ps
module plfm_exec_assertions
    import plfm_pkg::*;
(
    // watched ports
    input  wire                  clk,
    input  wire                  rstn,
    input  wire                  instrValid,
    input  wire plfm_pkg::plfm_byte_t memAddr,
    input  wire                  memWrEn,
    input  wire plfm_pkg::plfm_byte_t accValue,
    input  wire                  zeroFlag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // no fetch for a whole instruction slot
    sequence s_quiet;
        (!instrValid) [*4];
    endsequence
    a_write_once: assert property (memWrEn |=> !memWrEn [*3])
        else $error("two writes within one instruction slot");
    a_acc_not_mem: assert property (memWrEn |-> memAddr != 8'h0A)
        else $error("accumulator address reached the memory port");
    a_ptr_resolved: assert property (memWrEn |-> memAddr != 8'h00 && memAddr != 8'h08)
        else $error("indirect register written instead of its target");
    a_acc_holds: assert property (s_quiet |=> $stable(accValue))
        else $error("accumulator moved with no instruction");
    a_flag_holds: assert property (s_quiet |=> $stable(zeroFlag))
        else $error("zero flag moved with no instruction");
    a_reset_clean: assert property ($rose(rstn) |-> !memWrEn && accValue == 8'h00)
        else $error("outputs not cleared by reset");
endmodule
bind plfm_exec plfm_exec_assertions plfm_exec_assertions_inst (.clk(clk), .rstn(rstn),
    .instrValid(instrValid), .memAddr(memAddr), .memWrEn(memWrEn), .accValue(accValue),
    .zeroFlag(zeroFlag));

// ### tb_plfm_exec.sv
// self-checking bench for the move executor
// assumes the memory model and checker are compiled first
`timescale 1ns/100ps
module tb_plfm_exec;
    import plfm_pkg::*;
    logic       clk = 1'b0, rstn = 1'b0, clkEn = 1'b0, instrValid = 1'b0;
    logic       memWrEn, zeroFlag, busy;
    plfm_word_t instrWord = 16'h0000;
    plfm_byte_t ptr0 = 8'h00, ptr1 = 8'h00, memRdData, memAddr, memWrData, accValue;
    int         errors = 0, samples_checked = 0, cycles = 0;
    plfm_exec plfm_exec_inst (.clk(clk), .rstn(rstn), .clkEn(clkEn), .instrWord(instrWord),
        .instrValid(instrValid), .ptr0(ptr0), .ptr1(ptr1), .memRdData(memRdData),
        .memAddr(memAddr), .memWrData(memWrData), .memWrEn(memWrEn),
        .accValue(accValue), .zeroFlag(zeroFlag), .busy(busy));
    plfm_data_mem plfm_data_mem_inst (.clk(clk), .addr(memAddr), .wrData(memWrData),
        .wrEn(memWrEn), .rdData(memRdData));
    initial forever #10 clk = ~clk;
    // hang guard, the run needs under a hundred cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input plfm_byte_t got, input plfm_byte_t exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one slot of four cycles, then an idle slot to keep phase alignment
    task automatic run(input plfm_word_t w, input logic expBusy);
        instrWord = w;
        instrValid = 1'b1;
        repeat (2) @(negedge clk);
        chk({7'h0, busy}, {7'h0, expBusy});
        repeat (2) @(negedge clk);
        instrValid = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // direct moves at the field boundaries, accumulator both ways
    task automatic t_direct();
        run(16'h5F0A, 1'b1);
        chk(accValue, 8'h18);
        chk({7'h0, zeroFlag}, 8'h00);
        run(16'h47FF, 1'b1);
        chk(plfm_data_mem_inst.mem[8'hFF], 8'h00);
        chk({7'h0, zeroFlag}, 8'h01);
        run(16'h0180, 1'b1);
        chk(plfm_data_mem_inst.mem[8'h80], 8'h18);
        chk({7'h0, zeroFlag}, 8'h01);
        run(16'h4A90, 1'b1);
        chk(plfm_data_mem_inst.mem[8'h90], 8'h18);
    endtask
    // both operands through the pointers, then a foreign opcode
    task automatic t_indirect();
        ptr0 = 8'h40;
        ptr1 = 8'hC0;
        run(16'h4008, 1'b1);
        chk(plfm_data_mem_inst.mem[8'hC0], 8'h47);
        run(16'hB0AA, 1'b0);
        chk(accValue, 8'h18);
    endtask
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        clkEn = 1'b1;
        t_direct();
        t_indirect();
        repeat (8) @(negedge clk);
        print_verdict();
    end
endmodule
